//--- hdl/fpa_unit.sv
// fixed-point add datapath: decode, operand selection, add, flags, write back
// Overview of operation
// - second operand from register, memory fullword, or instruction stream; first is register
// - halfword memory operand sign-extended to 32 bits before adding
// - halfword multiply skips the general sign extension
// - fullword multiply writes a 64-bit product to an adjacent register pair
// - fullword divide reads its 64-bit dividend from an adjacent register pair
// - all but multiply and divide update the condition code from the result
// - add treats every bit, sign included, as two's complement
// - carry set when the unsigned sum overflows out of bit 31
// - overflow set when the signed result does not fit
// - condition code order is carry, overflow, greater, less
// - without overflow: greater for positive, less for negative, none for zero
// - add sums operand with destination register and writes it back there
// - add opcodes 5a memory, 0a register, fa immediate, 26 short
// - short immediate 4-bit field zero-extended to 32 bits
// - full immediate operand is immediate plus index register
// - decode four families: register, short, indexed storage, immediate
// - sign is the most significant bit; negatives in two's complement
`timescale 1ns/1ns
`default_nettype none
module fpa_unit
    import fpa_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                resetn,
    input  wire logic                clkEn,
    input  wire logic                instValid,
    input  wire logic [7:0]          opcode,
    input  wire logic [RSEL_W-1:0]   dest_reg_field,
    input  wire logic [RSEL_W-1:0]   src_reg_field,
    input  wire logic [RSEL_W-1:0]   index_reg_field,
    input  wire logic [WORD_W-1:0]   imm_field,
    input  wire logic [WORD_W-1:0]   memData,
    output logic                     busy,
    output logic                     done,
    output logic      [3:0]          condCode,
    output logic      [WORD_W-1:0]   result,
    output logic      [WORD_W-1:0]   resultLow,
    output logic                     illegalOp
);
    ////////////////////////////////////////////////////////////////////////
    // state
    typedef enum logic [1:0] {S_IDLE, S_READ, S_EXEC} fpa_state_t;

    typedef struct packed {
        fpa_state_t        state;
        fpa_kind_t         kind;
        fpa_family_t       family;
        logic [RSEL_W-1:0] dest;
        // second read select, latched at accept
        logic [RSEL_W-1:0] selB;
        logic [WORD_W-1:0] imm;
        logic [WORD_W-1:0] mem;
        logic [3:0]        cc;
        logic [WORD_W-1:0] res;
        logic [WORD_W-1:0] resLow;
        logic              busy;
        logic              done;
        logic              illegal;
    } fpa_regs_t;

    fpa_regs_t r;
    fpa_regs_t next_r;

    ////////////////////////////////////////////////////////////////////////
    // helpers
    // sign-extend a halfword to a fullword
    function automatic logic [WORD_W-1:0] sext_half(input logic [HALF_W-1:0] h);
        sext_half = {{(WORD_W-HALF_W){h[HALF_W-1]}}, h};
    endfunction

    // next register of an adjacent pair
    function automatic logic [RSEL_W-1:0] pair_of(input logic [RSEL_W-1:0] rsel);
        pair_of = rsel + 4'h1;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // register file and adder wiring
    logic [RSEL_W-1:0] rdAddrA;
    logic [RSEL_W-1:0] rdAddrB;
    logic [WORD_W-1:0] rdDataA;
    logic [WORD_W-1:0] rdDataB;
    logic              wrEnA;
    logic              wrEnB;
    logic [RSEL_W-1:0] wrAddrB;
    logic [WORD_W-1:0] wrDataA;
    logic [WORD_W-1:0] wrDataB;
    logic [WORD_W-1:0] addOpB;
    logic [WORD_W-1:0] addSum;
    logic [3:0]        addFlags;
    logic [WORD_W-1:0] idxSum;
    logic [63:0]       product;
    logic [63:0]       dividend;
    logic [WORD_W-1:0] quotient;
    logic [WORD_W-1:0] remainder;
    logic [WORD_W-1:0] mulHalfOp;

    fpa_reg_file u_regs (
        .mclk    (mclk),
        .resetn  (resetn),
        .clkEn   (clkEn),
        .rdAddrA (rdAddrA),
        .rdAddrB (rdAddrB),
        .rdDataA (rdDataA),
        .rdDataB (rdDataB),
        .wrEnA   (wrEnA),
        .wrAddrA (r.dest),
        .wrDataA (wrDataA),
        .wrEnB   (wrEnB),
        .wrAddrB (wrAddrB),
        .wrDataB (wrDataB)
    );

    fpa_adder u_add (
        .opA   (rdDataA),
        .opB   (addOpB),
        .sum   (addSum),
        .flags (addFlags)
    );

    ////////////////////////////////////////////////////////////////////////
    // read addresses: first operand always dest register, second by family
    // register forms read the source register, all others the index register
    always_comb
    begin
        if (r.state == S_IDLE)
        begin
            rdAddrA = dest_reg_field;
            rdAddrB = (opcode == OP_ADD_REG || opcode == OP_MUL_REG || opcode == OP_MUL_HREG
                       || opcode == OP_DIV_REG)
                      ? src_reg_field : index_reg_field;
        end
        else
        begin
            // inputs may move once accepted, so later reads use latched selects
            rdAddrA = r.dest;
            rdAddrB = r.selB;
            // divide: divisor was read at accept, now the low dividend word
            if (r.state == S_READ && r.kind == K_DIV)
                rdAddrB = pair_of(r.dest);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // second operand selection per family
    always_comb
    begin
        idxSum = r.imm + rdDataB;
        addOpB = rdDataB;
        unique case (r.family)
            FAM_REG_REG:   addOpB = rdDataB;
            FAM_SHORT:     addOpB = r.imm;
            FAM_INDEXED:   addOpB = (r.kind == K_ADD_HALF)
                                    ? sext_half(r.mem[HALF_W-1:0])
                                    : r.mem;
            FAM_IMMEDIATE: addOpB = (r.kind == K_ADD_HALF)
                                    ? r.imm + rdDataB
                                    : idxSum;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // multiply and divide datapaths, flags untouched
    always_comb
    begin
        // halfword multiply takes low 16 bits as is, no pre-extension
        mulHalfOp = {{(WORD_W-HALF_W){1'b0}}, r.mem[HALF_W-1:0]};
        if (r.family == FAM_REG_REG)
            mulHalfOp = {{(WORD_W-HALF_W){1'b0}}, rdDataB[HALF_W-1:0]};
        product  = $signed(rdDataA) * $signed((r.family == FAM_REG_REG) ? rdDataB : r.mem);
        dividend = {r.res, rdDataB};
        quotient  = WORD_RESET;
        remainder = WORD_RESET;
        if (r.mem != WORD_RESET)
        begin
            quotient  = 32'($signed(dividend) / $signed(r.mem));
            remainder = 32'($signed(dividend) % $signed(r.mem));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register file writes: add and paired results
    always_comb
    begin
        wrEnA   = 1'b0;
        wrEnB   = 1'b0;
        wrDataA = addSum;
        wrDataB = WORD_RESET;
        wrAddrB = pair_of(r.dest);
        if (r.state == S_EXEC)
        begin
            unique case (r.kind)
                K_ADD, K_ADD_HALF:
                begin
                    wrEnA   = 1'b1;
                    wrDataA = addSum;
                end
                K_MUL:
                begin
                    wrEnA   = 1'b1;
                    wrDataA = product[63:32];
                    wrEnB   = 1'b1;
                    wrDataB = product[31:0];
                end
                K_DIV:
                begin
                    wrEnA   = 1'b1;
                    wrDataA = remainder;
                    wrEnB   = 1'b1;
                    wrDataB = quotient;
                end
                K_MUL_HALF:
                begin
                    wrEnB   = 1'b1;
                    wrDataB = 32'($signed(rdDataA[HALF_W-1:0]) * $signed(mulHalfOp[HALF_W-1:0]));
                end
                default:
                begin
                    wrEnA = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decode and sequence
    always_comb
    begin
        next_r      = r;
        next_r.done = 1'b0;
        unique case (r.state)
            S_IDLE:
            begin
                if (instValid)
                begin
                    next_r.dest    = dest_reg_field;
                    next_r.selB    = rdAddrB;
                    next_r.mem     = memData;
                    next_r.illegal = 1'b0;
                    next_r.busy    = 1'b1;
                    next_r.state   = S_READ;
                    next_r.imm     = imm_field;
                    // decode into the four families
                    unique case (opcode)
                        OP_ADD_MEM:   begin next_r.kind = K_ADD;      next_r.family = FAM_INDEXED;   end
                        OP_ADD_REG:   begin next_r.kind = K_ADD;      next_r.family = FAM_REG_REG;   end
                        OP_ADD_IMM:   begin next_r.kind = K_ADD;      next_r.family = FAM_IMMEDIATE; end
                        OP_ADD_SHORT:
                        begin
                            next_r.kind   = K_ADD;
                            next_r.family = FAM_SHORT;
                            next_r.imm    = {28'h0000000, src_reg_field[SHORT_W-1:0]};
                        end
                        OP_ADD_HALF:  begin next_r.kind = K_ADD_HALF; next_r.family = FAM_INDEXED;   end
                        OP_ADD_HIMM:
                        begin
                            next_r.kind   = K_ADD_HALF;
                            next_r.family = FAM_IMMEDIATE;
                            next_r.imm    = sext_half(imm_field[HALF_W-1:0]);
                        end
                        OP_MUL_FULL:  begin next_r.kind = K_MUL;      next_r.family = FAM_INDEXED;   end
                        OP_MUL_REG:   begin next_r.kind = K_MUL;      next_r.family = FAM_REG_REG;   end
                        OP_DIV_FULL:  begin next_r.kind = K_DIV;      next_r.family = FAM_INDEXED;   end
                        OP_DIV_REG:   begin next_r.kind = K_DIV;      next_r.family = FAM_REG_REG;   end
                        OP_MUL_HALF:  begin next_r.kind = K_MUL_HALF; next_r.family = FAM_INDEXED;   end
                        OP_MUL_HREG:  begin next_r.kind = K_MUL_HALF; next_r.family = FAM_REG_REG;   end
                        default:
                        begin
                            next_r.kind    = K_NONE;
                            next_r.family  = FAM_REG_REG;
                            next_r.illegal = 1'b1;
                            next_r.busy    = 1'b0;
                            next_r.done    = 1'b1;
                            next_r.state   = S_IDLE;
                        end
                    endcase
                end
            end
            S_READ:
            begin
                // divide: keep high dividend word, take divisor from register form
                next_r.res = rdDataA;
                if (r.kind == K_DIV && r.family == FAM_REG_REG)
                    next_r.mem = rdDataB;
                next_r.state = S_EXEC;
            end
            S_EXEC:
            begin
                next_r.state = S_IDLE;
                next_r.busy  = 1'b0;
                next_r.done  = 1'b1;
                if (r.kind == K_ADD || r.kind == K_ADD_HALF)
                begin
                    next_r.res    = addSum;
                    next_r.resLow = WORD_RESET;
                    next_r.cc     = addFlags;
                end
                else
                begin
                    // multiply and divide leave the condition code alone
                    next_r.res    = wrEnA ? wrDataA : WORD_RESET;
                    next_r.resLow = wrDataB;
                end
            end
            // unused state code falls back to idle
            default:
            begin
                next_r.state = S_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            r         <= '0;
            r.state   <= S_IDLE;
            r.kind    <= K_NONE;
            r.family  <= FAM_REG_REG;
            r.cc      <= CC_RESET;
        end
        else if (clkEn)
            r <= next_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from the state register
    assign busy      = r.busy;
    assign done      = r.done;
    assign condCode  = r.cc;
    assign result    = r.res;
    assign resultLow = r.resLow;
    assign illegalOp = r.illegal;
endmodule
`default_nettype wire

//--- hdl/fpa_pkg.sv
// package of constants and types for the fixed-point add and flags unit
package fpa_pkg;
    // opcodes of the add, multiply and divide forms
    localparam logic [7:0] OP_ADD_MEM   = 8'h5a;
    localparam logic [7:0] OP_ADD_REG   = 8'h0a;
    localparam logic [7:0] OP_ADD_IMM   = 8'hfa;
    localparam logic [7:0] OP_ADD_SHORT = 8'h26;
    localparam logic [7:0] OP_ADD_HALF  = 8'h4a;
    localparam logic [7:0] OP_ADD_HIMM  = 8'hca;
    localparam logic [7:0] OP_MUL_FULL  = 8'h5c;
    localparam logic [7:0] OP_MUL_REG   = 8'h1c;
    localparam logic [7:0] OP_DIV_FULL  = 8'h5d;
    localparam logic [7:0] OP_DIV_REG   = 8'h1d;
    localparam logic [7:0] OP_MUL_HALF  = 8'h4c;
    localparam logic [7:0] OP_MUL_HREG  = 8'h0c;
    // widths
    localparam int WORD_W  = 32;
    localparam int HALF_W  = 16;
    localparam int SHORT_W = 4;
    localparam int REG_N   = 16;
    localparam int RSEL_W  = 4;
    // condition code bit positions, carry is most significant
    localparam int CC_C = 3;
    localparam int CC_V = 2;
    localparam int CC_G = 1;
    localparam int CC_L = 0;
    localparam logic [3:0]  CC_RESET   = 4'h0;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    // instruction encoding families
    typedef enum logic [1:0] {FAM_REG_REG, FAM_SHORT, FAM_INDEXED, FAM_IMMEDIATE} fpa_family_t;
    // kind of operation carried out
    typedef enum logic [2:0] {K_NONE, K_ADD, K_ADD_HALF, K_MUL, K_DIV, K_MUL_HALF} fpa_kind_t;
endpackage

//--- hdl/fpa_reg_file.sv
// general register file with two registered read ports and a paired write
`timescale 1ns/1ns
`default_nettype none
module fpa_reg_file
    import fpa_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                resetn,
    input  wire logic                clkEn,
    input  wire logic [RSEL_W-1:0]   rdAddrA,
    input  wire logic [RSEL_W-1:0]   rdAddrB,
    output logic      [WORD_W-1:0]   rdDataA,
    output logic      [WORD_W-1:0]   rdDataB,
    input  wire logic                wrEnA,
    input  wire logic [RSEL_W-1:0]   wrAddrA,
    input  wire logic [WORD_W-1:0]   wrDataA,
    input  wire logic                wrEnB,
    input  wire logic [RSEL_W-1:0]   wrAddrB,
    input  wire logic [WORD_W-1:0]   wrDataB
);
    logic [WORD_W-1:0] regs [REG_N];

    ////////////////////////////////////////////////////////////////////////
    // storage; port b writes second so a pair lands in two registers
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < REG_N; i++)
                regs[i] <= WORD_RESET;
            rdDataA <= WORD_RESET;
            rdDataB <= WORD_RESET;
        end
        else if (clkEn)
        begin
            if (wrEnA)
                regs[wrAddrA] <= wrDataA;
            if (wrEnB)
                regs[wrAddrB] <= wrDataB;
            rdDataA <= regs[rdAddrA];
            rdDataB <= regs[rdAddrB];
        end
    end
endmodule
`default_nettype wire

//--- hdl/fpa_adder.sv
// 32-bit two's complement adder producing the four-flag condition code
`timescale 1ns/1ns
`default_nettype none
module fpa_adder
    import fpa_pkg::*;
(
    input  wire logic [WORD_W-1:0] opA,
    input  wire logic [WORD_W-1:0] opB,
    output logic      [WORD_W-1:0] sum,
    output logic      [3:0]        flags
);
    logic [WORD_W:0] wide;
    logic            ovf;

    // all bits, sign included, add alike; no separate sign path
    always_comb
    begin
        wide = {1'b0, opA} + {1'b0, opB};
        sum  = wide[WORD_W-1:0];
        // operands alike in sign, result differs: magnitude overflowed
        ovf  = (opA[WORD_W-1] == opB[WORD_W-1]) && (sum[WORD_W-1] != opA[WORD_W-1]);
        flags        = 4'h0;
        flags[CC_C]  = wide[WORD_W];
        flags[CC_V]  = ovf;
        // sign sits in the top bit; g and l cleared on overflow
        flags[CC_G]  = !ovf && !sum[WORD_W-1] && (sum != WORD_RESET);
        flags[CC_L]  = !ovf && sum[WORD_W-1];
    end
endmodule
`default_nettype wire

//--- sim/fpa_unit_checker.sv
// concurrent checks on the ports of the fixed-point add unit
`timescale 1ns/1ns
`default_nettype none
module fpa_unit_checker
    import fpa_pkg::*;
(
    input wire logic              mclk,
    input wire logic              resetn,
    input wire logic              clkEn,
    input wire logic              instValid,
    input wire logic [7:0]        opcode,
    input wire logic              busy,
    input wire logic              done,
    input wire logic [3:0]        condCode,
    input wire logic [WORD_W-1:0] result,
    input wire logic [WORD_W-1:0] resultLow,
    input wire logic              illegalOp
);
    ////////////////////////////////////////////////////////////////////////////
    logic accept;
    logic lastAdd;
    // opcodes that run the adder and update the flags
    function automatic logic isAdd(input logic [7:0] op);
        return op inside {OP_ADD_MEM, OP_ADD_REG, OP_ADD_IMM, OP_ADD_SHORT, OP_ADD_HALF, OP_ADD_HIMM};
    endfunction
    function automatic logic isLegal(input logic [7:0] op);
        return isAdd(op) || (op inside {OP_MUL_FULL, OP_MUL_REG, OP_DIV_FULL, OP_DIV_REG, OP_MUL_HALF, OP_MUL_HREG});
    endfunction
    assign accept = clkEn && instValid && !busy;
    // remember whether the operation in flight is an add
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            lastAdd <= 1'b0;
        else if (accept)
            lastAdd <= isAdd(opcode);
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    add_latency_a: assert property (accept && isAdd(opcode) |=> busy ##1 busy ##1 (done && !busy))
        else $error("add did not complete three cycles after accept");
    illegal_done_a: assert property (accept && !isLegal(opcode) |=> done && illegalOp)
        else $error("unknown opcode not flagged at once");
    done_pulse_a: assert property (done |=> !done)
        else $error("done lasted more than one cycle");
    cc_hold_a: assert property (!done |-> $stable(condCode))
        else $error("condition code moved away from completion");
    muldiv_cc_a: assert property (done && !lastAdd |-> $stable(condCode))
        else $error("condition code changed by a non-add");
    less_sign_a: assert property (done && lastAdd && !condCode[CC_V] |-> condCode[CC_L] == result[31])
        else $error("less flag disagrees with result sign");
    greater_sign_a: assert property (done && lastAdd && !condCode[CC_V]
        |-> condCode[CC_G] == (!result[31] && result != 32'h0))
        else $error("greater flag disagrees with result");
    flag_excl_a: assert property (!(condCode[CC_G] && condCode[CC_L]))
        else $error("greater and less both set");
    add_low_a: assert property (done && lastAdd |-> resultLow == 32'h0)
        else $error("low result not cleared after add");
    cover property (done && condCode[CC_V]);
    cover property (done && condCode[CC_C]);
    cover property (done && illegalOp);
    cover property (done && !lastAdd && !illegalOp);
endmodule
bind fpa_unit fpa_unit_checker u_fpa_unit_checker (.mclk(mclk), .resetn(resetn), .clkEn(clkEn),
    .instValid(instValid), .opcode(opcode), .busy(busy), .done(done), .condCode(condCode),
    .result(result), .resultLow(resultLow), .illegalOp(illegalOp));
`default_nettype wire

//--- sim/fpa_mem_model.sv
// memory operand fetch model holding a few fullword-aligned words
`timescale 1ns/1ns
`default_nettype none
module fpa_mem_model
    import fpa_pkg::*;
(
    input  wire logic [1:0]        memSel,
    output logic      [WORD_W-1:0] memData
);
    // whole aligned fullwords only, never a split word
    always_comb
    begin
        case (memSel)
            2'h0:    memData = 32'h7f12_4321;
            2'h1:    memData = 32'h1234_ffff; // halfword in the low half, junk above
            2'h2:    memData = 32'h8000_0000;
            default: memData = 32'h5a5a_a5a5;
        endcase
    end
endmodule
`default_nettype wire

//--- sim/fpa_unit_tb.sv
// self-checking bench for the fixed-point add unit
`timescale 1ns/1ns
`default_nettype none
module fpa_unit_tb
    import fpa_pkg::*;
;
    logic              mclk = 1'b0;
    logic              resetn = 1'b0;
    logic              clkEn = 1'b1;
    logic              instValid = 1'b0;
    logic [7:0]        opcode = 8'h00;
    logic [RSEL_W-1:0] destReg = 4'h0;
    logic [RSEL_W-1:0] srcReg = 4'h0;
    logic [RSEL_W-1:0] indexReg = 4'h0;
    logic [WORD_W-1:0] imm = 32'h0;
    logic [1:0]        memSel = 2'h0;
    logic [WORD_W-1:0] memData;
    logic              busy, done, illegalOp;
    logic [3:0]        condCode;
    logic [WORD_W-1:0] result, resultLow;
    logic [WORD_W-1:0] regs [REG_N];
    logic [3:0]        lastCc;
    int                num_errors = 0;
    int                n_checks = 0;
    int                cycles = 0;
    ////////////////////////////////////////////////////////////////////////////
    fpa_mem_model u_fpa_mem_model (.memSel(memSel), .memData(memData));
    fpa_unit u_fpa_unit (.mclk(mclk), .resetn(resetn), .clkEn(clkEn), .instValid(instValid), .opcode(opcode),
        .dest_reg_field(destReg), .src_reg_field(srcReg), .index_reg_field(indexReg), .imm_field(imm),
        .memData(memData), .busy(busy), .done(done), .condCode(condCode), .result(result),
        .resultLow(resultLow), .illegalOp(illegalOp));
    // clock and hang limit
    always #4 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            num_errors++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    // present one instruction, then wait for its completion pulse
    task automatic issue(input logic [7:0] op, input logic [3:0] d, input logic [3:0] s, input logic [3:0] x,
                         input logic [31:0] iv, input logic [1:0] sel);
        int n;
        n = 0;
        @(posedge mclk);
        opcode <= op;
        destReg <= d;
        srcReg <= s;
        indexReg <= x;
        imm <= iv;
        memSel <= sel;
        instValid <= 1'b1;
        @(posedge mclk);
        instValid <= 1'b0;
        #1;
        // an illegal opcode completes on the accept edge itself
        while (done !== 1'b1 && n < 8)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        check("done", 64'h1, {63'h0, done});
    endtask
    // an add with its second operand b, checked against a reference sum and flags
    task automatic addChk(input logic [7:0] op, input logic [3:0] d, input logic [3:0] s, input logic [3:0] x,
                          input logic [31:0] iv, input logic [1:0] sel, input logic [31:0] b);
        logic [32:0] s33;
        logic        v;
        s33 = {1'b0, regs[d]} + {1'b0, b};
        v = (regs[d][31] == b[31]) && (s33[31] != b[31]);
        lastCc = {s33[32], v, !v && !s33[31] && s33[31:0] != 32'h0, !v && s33[31]};
        issue(op, d, s, x, iv, sel);
        regs[d] = s33[31:0];
        check("sum", {32'h0, s33[31:0]}, {32'h0, result});
        check("condCode", {60'h0, lastCc}, {60'h0, condCode});
        check("resultLow", 64'h0, {32'h0, resultLow});
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        foreach (regs[i]) regs[i] = 32'h0;
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        addChk(OP_ADD_IMM, 4'h1, 4'h0, 4'h0, 32'h7f34_1234, 2'h0, 32'h7f34_1234);
        addChk(OP_ADD_MEM, 4'h1, 4'h0, 4'h0, 32'h0, 2'h0, 32'h7f12_4321);
        addChk(OP_ADD_MEM, 4'h6, 4'h0, 4'h0, 32'h0, 2'h2, 32'h8000_0000);
        addChk(OP_ADD_IMM, 4'h2, 4'h0, 4'h0, 32'hffff_ffff, 2'h0, 32'hffff_ffff);
        addChk(OP_ADD_SHORT, 4'h3, 4'hf, 4'h0, 32'h0, 2'h0, 32'h0000_000f);
        addChk(OP_ADD_REG, 4'h3, 4'h2, 4'h0, 32'h0, 2'h0, regs[2]);
        addChk(OP_ADD_IMM, 4'h4, 4'h0, 4'h3, 32'h0000_0010, 2'h0, 32'h10 + regs[3]);
        addChk(OP_ADD_SHORT, 4'h2, 4'h1, 4'h0, 32'h0, 2'h0, 32'h1);
        addChk(OP_ADD_IMM, 4'h5, 4'h0, 4'h0, 32'h0023_0002, 2'h0, 32'h0023_0002);
        addChk(OP_ADD_HALF, 4'h5, 4'h0, 4'h0, 32'h0, 2'h1, 32'hffff_ffff);
        addChk(OP_ADD_SHORT, 4'h8, 4'h3, 4'h0, 32'h0, 2'h0, 32'h3);
        addChk(OP_ADD_SHORT, 4'h9, 4'h3, 4'h0, 32'h0, 2'h0, 32'h3);
        addChk(OP_ADD_SHORT, 4'ha, 4'h5, 4'h0, 32'h0, 2'h0, 32'h5);
        // pair multiply then divide back, flags must not move
        issue(OP_MUL_REG, 4'h8, 4'ha, 4'h0, 32'h0, 2'h0);
        check("product", 64'd15, {result, resultLow});
        check("mul flags", {60'h0, lastCc}, {60'h0, condCode});
        issue(OP_DIV_REG, 4'h8, 4'ha, 4'h0, 32'h0, 2'h0);
        check("quotient", {32'h0, 32'h3}, {result, resultLow});
        check("div flags", {60'h0, lastCc}, {60'h0, condCode});
        regs[8] = 32'h0;
        regs[9] = 32'h3;
        addChk(OP_ADD_SHORT, 4'h9, 4'h0, 4'h0, 32'h0, 2'h0, 32'h0);
        addChk(OP_ADD_SHORT, 4'h8, 4'h0, 4'h0, 32'h0, 2'h0, 32'h0);
        // an opcode outside the decoded set
        issue(8'hff, 4'h1, 4'h0, 4'h0, 32'h0, 2'h0);
        check("illegalOp", 64'h1, {63'h0, illegalOp});
        check("illegal flags", {60'h0, lastCc}, {60'h0, condCode});
        addChk(OP_ADD_REG, 4'h1, 4'h4, 4'h0, 32'h0, 2'h0, regs[4]);
        check("illegal cleared", 64'h0, {63'h0, illegalOp});
        addChk(OP_ADD_HIMM, 4'h9, 4'h0, 4'h0, 32'h0000_fff2, 2'h0, 32'hffff_fff2);
        // halfword multiply writes only the partner register
        issue(OP_MUL_HREG, 4'h3, 4'ha, 4'h0, 32'h0, 2'h0);
        check("half product", {32'h0, 32'h46}, {result, resultLow});
        check("mhr flags", {60'h0, lastCc}, {60'h0, condCode});
        regs[4] = 32'h46;
        addChk(OP_ADD_SHORT, 4'h4, 4'h0, 4'h0, 32'h0, 2'h0, 32'h0);
        summarize();
    end
endmodule
`default_nettype wire
